// [lec_top.sv]
// Lane error counter control and status with a classic Wishbone register slave.
// Assumes error pulses and lane enable levels come from receiver logic on clk.
// Assumes hold writes come only while the deframer is held in soft reset;
// nothing here sees that reset, so the block does not gate them.
`timescale 1ns/100ps
`default_nettype none
`include "lec_map.svh"

module lec_top
    import lec_pkg::*;
#(
    parameter int LANES = 8
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [12:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [LANES-1:0] unexpected_control_char_error,
    input wire logic [LANES-1:0] not_in_table_error,
    input wire logic [LANES-1:0] bad_disparity_error,
    input wire logic [LANES-1:0] lane_enabled
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------------
    logic [10:0] idx;
    logic req;
    logic wr;
    logic ctrl_hit;
    logic hold_hit;
    logic stat_hit;
    logic cnt_hit;
    logic [2:0] rd_lane;
    logic [2:0] cnt_lane;
    logic [1:0] cnt_type;
    logic [31:0] rd_word;

    // A new request is one not yet answered; a write lands on the acknowledging edge.
    assign idx = wb_adr_i[12:2];
    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
    assign ctrl_hit = (idx & `LEC_MASK_GROUP8) == `LEC_IDX_CTRL0;
    assign hold_hit = (idx & `LEC_MASK_GROUP8) == `LEC_IDX_HOLD0;
    assign stat_hit = (idx & `LEC_MASK_GROUP8) == `LEC_IDX_STAT0;
    assign cnt_hit = ((idx & `LEC_MASK_GROUP32) == `LEC_IDX_COUNT0) && (idx[1:0] != 2'h3);
    assign rd_lane = idx[2:0];
    assign cnt_lane = idx[4:2];
    assign cnt_type = idx[1:0];

    // ------------------------------------------------------------------------
    // Per-lane registers and counter banks
    // ------------------------------------------------------------------------
    logic [5:0] ctrl [8];
    logic [2:0] hold [8];
    logic [2:0] reached [8];
    lec_cnt_t cnt [8][3];

    lec_cnt_if lane_if [LANES] ();

    genvar l;
    generate
        for (l = 0; l < 8; l++)
        begin : g_lane
            if (l < LANES)
            begin : g_used
                // Control holds enables in [5:3] and counter resets in [2:0].
                always_ff @(posedge clk or negedge rst_n)
                begin
                    if (!rst_n)
                        ctrl[l] <= `LEC_CTRL_RESET;
                    else if (wr && ctrl_hit && rd_lane == 3'(l))
                        ctrl[l] <= wb_dat_i[5:0];
                end

                // Hold field; written safely only while the deframer is held in soft reset.
                // A write in normal operation changes the mode at once, so a counter
                // sitting at 0xFF then sticks or rolls over at its next error.
                always_ff @(posedge clk or negedge rst_n)
                begin
                    if (!rst_n)
                        hold[l] <= `LEC_HOLD_RESET;
                    else if (wr && hold_hit && rd_lane == 3'(l))
                        hold[l] <= wb_dat_i[2:0];
                end

                // Bit 2 control char, bit 1 not-in-table, bit 0 disparity.
                assign lane_if[l].err = {unexpected_control_char_error[l],
                    not_in_table_error[l], bad_disparity_error[l]};
                assign lane_if[l].en = ctrl[l][5:`LEC_CTRL_EN_LSB];
                assign lane_if[l].clr = ctrl[l][2:0];
                assign lane_if[l].hold = hold[l];
                assign reached[l] = lane_if[l].reached;
                assign cnt[l] = lane_if[l].count;

                lec_lane_counters u_bank
                (
                    .clk(clk),
                    .rst_n(rst_n),
                    .cif(lane_if[l])
                );
            end
            else
            begin : g_absent
                // Lanes beyond the configured count read as zero.
                assign ctrl[l] = 6'h00;
                assign hold[l] = 3'h0;
                assign reached[l] = 3'h0;
                assign cnt[l] = '{8'h00, 8'h00, 8'h00};
            end
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Read selection
    // ------------------------------------------------------------------------
    logic [LANES-1:0] lane_flag;
    logic [7:0] lane_flag8;
    logic [7:0] stat_byte;

    // Status bit 3 shows whether the lane is enabled; upper bits read zero.
    assign lane_flag = lane_enabled;
    assign lane_flag8 = 8'(lane_flag);
    assign stat_byte = {4'h0, lane_flag8[rd_lane], reached[rd_lane]};

    // Pick the addressed register; counts sit four indices per lane, the fourth a gap.
    assign rd_word = ctrl_hit ? {26'h0, ctrl[rd_lane]} :
        hold_hit ? {29'h0, hold[rd_lane]} :
        stat_hit ? {24'h0, stat_byte} :
        cnt_hit ? {24'h0, cnt[cnt_lane][cnt_type]} : 32'h0;

    // Answer every request one cycle later; unmapped reads return zero.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= req;
    end

    // Read data is captured with the request so it is valid alongside ack.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            wb_dat_o <= 32'h0;
        else if (req)
            wb_dat_o <= rd_word;
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    a_ack_one_cycle : assert property (
        req |=> wb_ack_o ##1 !wb_ack_o
    ) else $error("ack not a single cycle after request");

    a_status_lane : assert property (
        req && !wb_we_i && stat_hit |=> wb_dat_o[`LEC_STAT_LANE_BIT] == $past(lane_flag8[rd_lane])
    ) else $error("lane enabled status wrong");

    a_reserved_zero : assert property (
        req && !wb_we_i && (hold_hit || stat_hit) |=> wb_dat_o[31:4] == 28'h0
    ) else $error("reserved status or hold bits not zero");

    a_hold_write : assert property (
        wr && hold_hit |=> hold[$past(rd_lane)] == $past(wb_dat_i[2:0])
    ) else $error("hold field write lost");

    a_status_reset : assert property (
        $rose(rst_n) |-> wb_dat_o == 32'h0 && !wb_ack_o
    ) else $error("status output not zero after reset");

    // A hold read returns the field in [2:0] with every bit above it zero.
    a_hold_readback : assert property (
        req && !wb_we_i && hold_hit |=> wb_dat_o == {29'h0, $past(hold[rd_lane])}
    ) else $error("hold field read back wrong");

    // A status read returns the sticky terminal flags of the addressed lane.
    a_flag_readback : assert property (
        req && !wb_we_i && stat_hit |=> wb_dat_o[2:0] == $past(reached[rd_lane])
    ) else $error("terminal flags read back wrong");

    // A control write lands the enables and counter resets of the addressed lane.
    a_ctrl_write : assert property (
        wr && ctrl_hit |=> ctrl[$past(rd_lane)] == $past(wb_dat_i[5:0])
    ) else $error("control write lost");

    // A count read returns the eight-bit counter with zeros above it.
    a_count_readback : assert property (
        req && !wb_we_i && cnt_hit |=> wb_dat_o == {24'h0, $past(cnt[cnt_lane][cnt_type])}
    ) else $error("counter read back wrong");

    // Reads of unmapped indices, the count gap included, return zero.
    a_unmapped_zero : assert property (
        req && !wb_we_i && !ctrl_hit && !hold_hit && !stat_hit && !cnt_hit |=> wb_dat_o == 32'h0
    ) else $error("unmapped read not zero");

    // Hold bits come out of reset set, so every counter saturates by default.
    a_hold_reset : assert property (
        $rose(rst_n) |-> hold[LANES-1] == `LEC_HOLD_RESET
    ) else $error("hold field not set after reset");

endmodule : lec_top

`default_nettype wire

// [lec_map.svh]
// Register map, field positions, reset values and timing for the lane error counter block.
// Assumes word-aligned classic Wishbone access with the register index in address bits [12:2].
`ifndef LEC_MAP_SVH
`define LEC_MAP_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define LEC_IDX_CTRL0      11'h480
`define LEC_IDX_HOLD0      11'h488
`define LEC_IDX_HOLD4      11'h48C
`define LEC_IDX_HOLD5      11'h48D
`define LEC_IDX_HOLD6      11'h48E
`define LEC_IDX_HOLD7      11'h48F
`define LEC_IDX_STAT0      11'h490
`define LEC_IDX_COUNT0     11'h4A0
`define LEC_MASK_GROUP8    11'h7F8
`define LEC_MASK_GROUP32   11'h7E0

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define LEC_CTRL_EN_LSB    3
`define LEC_STAT_LANE_BIT  3
`define LEC_BIT_UNEXP      2
`define LEC_BIT_NOT_IN_TABLE 1
`define LEC_BIT_DISPARITY 0

// ----------------------------------------------------------------------------
// Reset values and counter figures
// ----------------------------------------------------------------------------
`define LEC_CTRL_RESET     6'h3F
`define LEC_HOLD_RESET     3'h7
`define LEC_STAT_RESET     8'h00
`define LEC_CNT_TERMINAL   8'hFF
`define LEC_CNT_LAST       8'hFE
`define LEC_ACK_LATENCY    1

`endif

// [lec_pkg.sv]
// Types shared by the lane error counter block.
// Assumes the map header supplies all numeric constants.
`default_nettype none

package lec_pkg;

    // One eight-bit error counter value.
    typedef logic [7:0] lec_cnt_t;

    // Position of each error type within a three-bit lane field.
    typedef enum logic [1:0]
    {
        LEC_ERR_DISPARITY = 2'b00,
        LEC_ERR_NOT_IN_TABLE = 2'b01,
        LEC_ERR_UNEXP = 2'b10
    } lec_err_t;

endpackage : lec_pkg

`default_nettype wire

// [lec_cnt_if.sv]
// Signals between the register block and one lane's counter bank.
// Assumes both ends share one clock.
`timescale 1ns/100ps
`default_nettype none

interface lec_cnt_if
    import lec_pkg::*;
();
    logic [2:0] err;
    logic [2:0] en;
    logic [2:0] clr;
    logic [2:0] hold;
    logic [2:0] reached;
    lec_cnt_t count [3];

    modport ctl
    (
        output err,
        output en,
        output clr,
        output hold,
        input reached,
        input count
    );
    modport bank
    (
        input err,
        input en,
        input clr,
        input hold,
        output reached,
        output count
    );
endinterface : lec_cnt_if

`default_nettype wire

// [lec_lane_counters.sv]
// Three eight-bit error counters for one lane, with hold and terminal flags.
// Assumes error strobes are single-cycle pulses on the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "lec_map.svh"

module lec_lane_counters
    import lec_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    lec_cnt_if.bank cif
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    genvar t;
    generate
        for (t = 0; t < 3; t++)
        begin : g_type
            lec_cnt_t count;
            logic reached;
            logic inc;
            logic at_top;
            logic stuck;
            logic set_reached;

            // ----------------------------------------------------------------
            // Count decision
            // ----------------------------------------------------------------
            // Counts only when enabled and not being cleared; a held counter sticks at top.
            assign inc = cif.en[t] & cif.err[t] & ~cif.clr[t];
            assign at_top = (count == `LEC_CNT_TERMINAL);
            assign stuck = at_top & cif.hold[t];
            assign set_reached = inc & (count == `LEC_CNT_LAST);

            // Clear wins over counting; otherwise add one and let eight bits wrap, unless held at top.
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                    count <= 8'h00;
                else if (cif.clr[t])
                    count <= 8'h00;
                else if (inc && !stuck)
                    count <= count + 8'h01;
            end

            // Flag is sticky until cleared; a clear blocks a new terminal hit in the same cycle.
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                    reached <= 1'b0;
                else
                    reached <= set_reached | (reached & ~cif.clr[t]);
            end

            assign cif.count[t] = count;
            assign cif.reached[t] = reached;

            a_hold_saturate : assert property (
                cif.hold[t] && at_top && !cif.clr[t] |=> count == `LEC_CNT_TERMINAL
            ) else $error("held counter left terminal value");

            a_wrap_rollover : assert property (
                !cif.hold[t] && at_top && inc |=> count == 8'h00
            ) else $error("counter did not roll over");

            a_clear_zero : assert property (
                cif.clr[t] |=> count == 8'h00 && !$past(set_reached)
            ) else $error("counter reset did not clear");

            a_enable_gate : assert property (
                !cif.en[t] && !cif.clr[t] |=> $stable(count)
            ) else $error("disabled counter moved");

            a_reach_flag : assert property (
                count == `LEC_CNT_LAST && inc |=> reached && at_top ##1 (reached || $past(cif.clr[t]))
            ) else $error("terminal flag not set on reaching top");
        end
    endgenerate

endmodule : lec_lane_counters

`default_nettype wire

// [lec_link_model.sv]
// Behavioural link transmitter: sends bursts of error pulses on one lane.
// Assumes the bench starts a burst with a one-cycle go and then waits on busy.
`timescale 1ns/100ps
`default_nettype none

module lec_link_model
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic go,
    input wire logic [2:0] lane,
    input wire logic [1:0] kind,
    input wire logic [9:0] len,
    input wire logic [7:0] ena_mask,
    output logic [7:0] unexpected_control_char_error,
    output logic [7:0] not_in_table_error,
    output logic [7:0] bad_disparity_error,
    output logic [7:0] lane_enabled,
    output logic busy
);
    logic [9:0] left;
    logic [7:0] hot;

    // One error type on one lane, one pulse per cycle, back to back.
    assign busy = (left != 10'h000);
    assign hot = busy ? (8'h01 << lane) : 8'h00;
    assign bad_disparity_error = (kind == 2'h0) ? hot : 8'h00;
    assign not_in_table_error = (kind == 2'h1) ? hot : 8'h00;
    assign unexpected_control_char_error = (kind == 2'h2) ? hot : 8'h00;
    assign lane_enabled = ena_mask;

    // Burst length counter.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            left <= 10'h000;
        else if (go)
            left <= len;
        else if (busy)
            left <= left - 10'h001;
    end
endmodule : lec_link_model

`default_nettype wire

// [lane_error_counter_hold_ctrl_test.sv]
// Self-checking bench for the lane error counter block over classic Wishbone.
// Assumes the link model drives the error pulses and the lane enable levels.
`timescale 1ns/100ps
`default_nettype none
`include "lec_map.svh"

module lane_error_counter_hold_ctrl_test;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [12:0] wb_adr = 13'h0000;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat = 32'h00000000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic go = 1'b0;
    logic [1:0] kind = 2'h0;
    logic [9:0] len = 10'h000;
    logic [7:0] ena_mask = 8'h00;
    logic [7:0] ctl_char_err, table_err, disp_err, lane_en;
    logic busy;
    logic [31:0] rd;
    int fail_count = 0;
    int cmp_count = 0;
    int cycles = 0;

    // ------------------------------------------------------------------
    // Clock, timeout and instances
    // ------------------------------------------------------------------
    always #2.5 clk = ~clk;

    // Cuts a hung run short.
    always @(posedge clk)
    begin
        cycles = cycles + 1;
        if (cycles == 8000)
        begin
            fail_count++;
            $display("MISMATCH %0t run timed out", $time);
            end_of_test();
        end
    end

    lec_top #(.LANES(8)) uut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .unexpected_control_char_error(ctl_char_err),
        .not_in_table_error(table_err), .bad_disparity_error(disp_err), .lane_enabled(lane_en));

    lec_link_model link (.clk(clk), .rst_n(rst_n), .go(go), .lane(3'h4), .kind(kind),
        .len(len), .ena_mask(ena_mask), .unexpected_control_char_error(ctl_char_err),
        .not_in_table_error(table_err), .bad_disparity_error(disp_err), .lane_enabled(lane_en),
        .busy(busy));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task end_of_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_of_test

    task check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    // One classic cycle; held until ack is sampled high, then released.
    task wb(input logic we, input logic [10:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= {idx, 2'b00};
        wb_sel <= 4'h1;
        wb_dat <= {24'h000000, d};
        @(posedge clk);
        while (wb_ack_o !== 1'b1 && n < 20)
        begin
            n++;
            @(posedge clk);
        end
        if (n == 20)
        begin
            fail_count++;
            $display("MISMATCH %0t bus cycle not acknowledged", $time);
        end
        rd = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask : wb

    task rd_chk(input logic [10:0] idx, input logic [31:0] exp);
        wb(1'b0, idx, 8'h00);
        check(rd, exp);
    endtask : rd_chk

    // Sends a burst of pulses of one error type on lane 4.
    task burst(input logic [1:0] k, input logic [9:0] n_pulses);
        int n;
        n = 0;
        @(posedge clk);
        kind <= k;
        len <= n_pulses;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        while (busy && n < 2000)
        begin
            n++;
            @(posedge clk);
        end
        if (n == 2000)
        begin
            fail_count++;
            $display("MISMATCH %0t error burst did not finish", $time);
        end
    endtask : burst

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 4; i++)
            rd_chk(`LEC_IDX_HOLD4 + 11'(i), 32'h00000007);
        rd_chk(`LEC_IDX_STAT0, 32'h00000000);
        rd_chk(11'h000, 32'h00000000);
        wb(1'b1, `LEC_IDX_HOLD4, 8'hFD);
        rd_chk(`LEC_IDX_HOLD4, 32'h00000005);
        for (int i = 1; i < 4; i++)
        begin
            wb(1'b1, `LEC_IDX_HOLD4 + 11'(i), 8'(i));
            rd_chk(`LEC_IDX_HOLD4 + 11'(i), 32'(i));
        end
        wb(1'b1, `LEC_IDX_STAT0, 8'hFF);
        rd_chk(`LEC_IDX_STAT0, 32'h00000000);
        ena_mask <= 8'h01;
        rd_chk(`LEC_IDX_STAT0, 32'h00000008);
        ena_mask <= 8'h00;
        rd_chk(`LEC_IDX_STAT0, 32'h00000000);
        rd_chk(`LEC_IDX_CTRL0 + 11'h004, 32'h0000003F);
        wb(1'b1, `LEC_IDX_CTRL0 + 11'h004, 8'h38);
        burst(2'h2, 10'd300);
        rd_chk(`LEC_IDX_COUNT0 + 11'h012, 32'h000000FF);
        rd_chk(`LEC_IDX_STAT0 + 11'h004, 32'h00000004);
        burst(2'h1, 10'd257);
        rd_chk(`LEC_IDX_COUNT0 + 11'h011, 32'h00000001);
        rd_chk(`LEC_IDX_STAT0 + 11'h004, 32'h00000006);
        wb(1'b1, `LEC_IDX_CTRL0 + 11'h004, 8'h30);
        rd_chk(`LEC_IDX_CTRL0 + 11'h004, 32'h00000030);
        burst(2'h0, 10'd5);
        rd_chk(`LEC_IDX_COUNT0 + 11'h010, 32'h00000000);
        wb(1'b1, `LEC_IDX_CTRL0 + 11'h004, 8'h34);
        wb(1'b1, `LEC_IDX_CTRL0 + 11'h004, 8'h30);
        rd_chk(`LEC_IDX_COUNT0 + 11'h012, 32'h00000000);
        rd_chk(`LEC_IDX_STAT0 + 11'h004, 32'h00000002);
        wb(1'b1, `LEC_IDX_COUNT0 + 11'h011, 8'h55);
        rd_chk(`LEC_IDX_COUNT0 + 11'h011, 32'h00000001);
        rd_chk(`LEC_IDX_COUNT0 + 11'h013, 32'h00000000);
        end_of_test();
    end
endmodule : lane_error_counter_hold_ctrl_test

`default_nettype wire
